/* common/pls_pkg.sv */
/*
 Constants, register map, field positions and types for the link status and
 interrupt block. Assumes a single device clock and an 8-bit register port.
*/
package pls_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] REG_STATUS = 8'hc4;
   localparam logic [7:0] REG_IRQ_EN = 8'hc6;
   localparam logic [7:0] REG_IRQ_ST = 8'hc7;
   localparam logic [7:0] REG_CTRL = 8'hc8;
   localparam logic [7:0] REG_CFG = 8'hc9;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Link status bits
   localparam int ST_LINK_ERR = 7;
   localparam int ST_REMOTE_IRQ = 6;
   localparam int ST_LOCK = 5;
   localparam int ST_PLUG = 4;
   localparam int ST_FOUND = 3;
   localparam int ST_LIST_RDY = 2;
   localparam int ST_KEY_RDY = 1;
   localparam int ST_AUTH_DONE = 0;
   // Interrupt enable / status bits
   localparam int IRQ_INDIRECT = 7;
   localparam int IRQ_FOUND = 6;
   localparam int IRQ_REMOTE = 5;
   localparam int IRQ_LIST = 4;
   localparam int IRQ_KEY = 3;
   localparam int IRQ_FAIL = 2;
   localparam int IRQ_PASS = 1;
   localparam int IRQ_GLOBAL = 0;
   // Own control register bits (approval writes are one-shot; the enable bit is held)
   localparam int CTL_KEY_OK = 4;
   localparam int CTL_LIST_OK = 5;
   localparam int CTL_ENABLE = 0;
   // Own configuration register bits
   localparam int CFG_NEEDS_LOCK = 1;
   localparam int CFG_REPEATER = 2;

   typedef enum logic [1:0] {PLS_AUTH_IDLE, PLS_AUTH_RUN, PLS_AUTH_WAIT} pls_auth_t;
endpackage : pls_pkg

/* logic/pls_edge.sv */
/*
 Rising-edge detector for one synchronous level.
 Assumes the level is already synchronous to clk.
*/
module pls_edge
   import pls_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Level in, pulse out
   input wire logic level,
   output logic rise
);
   typedef struct packed {logic prev;} pls_edge_st_t;
   pls_edge_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.prev = level;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rise = level & ~s_q.prev;
endmodule : pls_edge

/* logic/pls_sticky.sv */
/*
 One-bit sticky flag: set wins over clear.
 Assumes set and clear are one-cycle synchronous pulses or levels.
*/
module pls_sticky
   import pls_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic set,
   input wire logic clr,
   output logic flag
);
   typedef struct packed {logic f;} pls_stk_st_t;
   pls_stk_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (set) begin
         s_d.f = 1'b1;
      end else if (clr) begin
         s_d.f = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign flag = s_q.f;
endmodule : pls_sticky

/* logic/pls_top.sv */
/*
 Link status, interrupt enable and interrupt status registers of the
 content-protection transmitter, with the authentication stall handshake.
 Assumes events from the authentication engine and the link are synchronous
 one-cycle pulses or levels on clk, and a plain register port.
*/
module pls_top
   import pls_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire logic [pls_pkg::ADDR_W-1:0] addr,
   input wire logic [pls_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [pls_pkg::DATA_W-1:0] rdata,
   // Link and engine events
   input wire logic link_error_pulse,
   input wire logic remote_irq_input,
   input wire logic remote_lock_flag,
   input wire logic downstream_plug_pulse,
   input wire logic receiver_found_flag,
   input wire logic key_list_loaded,
   input wire logic receiver_key_loaded,
   input wire logic auth_pass_pulse,
   input wire logic auth_fail_pulse,
   input wire logic indirect_done_pulse,
   // To the authentication engine
   output logic auth_stall,
   output logic auth_enabled,
   output logic auth_restart,
   // To the controller
   output logic irq_out
);
   import pls_pkg::*;

   typedef struct packed {
      logic [7:0] rdata;
      logic [7:0] irq_en;
      logic [7:0] irq_st;
      logic auth_done_flag;
      logic needs_lock;
      logic repeater;
      logic enabled;
      logic restart;
      pls_auth_t auth;
   } pls_st_t;

   pls_st_t s_q, s_d;
   logic link_error_flag, downstream_plug_flag, key_list_ready, receiver_key_ready;
   logic wr_ctl, rd_status, rd_irq;
   logic list_approved, key_approved;
   logic found_cond, found_rise, remote_rise;
   logic [7:0] status_byte, events;

   function automatic logic hit(input logic s, input logic [7:0] a, input logic [7:0] r);
      hit = s & (a == r);
   endfunction : hit

   // Summary of enabled, pending sources; bit 0 of either byte plays no part
   function automatic logic any_enabled(input logic [7:0] st, input logic [7:0] en);
      any_enabled = |(st[IRQ_INDIRECT:IRQ_PASS] & en[IRQ_INDIRECT:IRQ_PASS]);
   endfunction : any_enabled

   assign rd_status = hit(rd, addr, REG_STATUS);
   assign rd_irq = hit(rd, addr, REG_IRQ_ST);
   assign wr_ctl = hit(wr, addr, REG_CTRL);
   assign list_approved = wr_ctl & wdata[CTL_LIST_OK];
   assign key_approved = wr_ctl & wdata[CTL_KEY_OK];

   pls_sticky u_err (.clk(clk), .rst_b(rst_b), .set(link_error_pulse),
      .clr(rd_status), .flag(link_error_flag));
   pls_sticky u_plug (.clk(clk), .rst_b(rst_b), .set(downstream_plug_pulse),
      .clr(rd_status), .flag(downstream_plug_flag));
   pls_sticky u_list (.clk(clk), .rst_b(rst_b), .set(key_list_loaded),
      .clr(list_approved), .flag(key_list_ready));
   pls_sticky u_key (.clk(clk), .rst_b(rst_b), .set(receiver_key_loaded),
      .clr(key_approved | auth_fail_pulse), .flag(receiver_key_ready));

   // Detect interrupt may wait for lock; the edge of the combined level fires it
   assign found_cond = receiver_found_flag & (~s_q.needs_lock | remote_lock_flag);
   pls_edge u_found (.clk(clk), .rst_b(rst_b), .level(found_cond), .rise(found_rise));
   // Remote interrupt pin is active low, so its fall is the request
   pls_edge u_remote (.clk(clk), .rst_b(rst_b), .level(~remote_irq_input),
      .rise(remote_rise));

   assign status_byte = {link_error_flag, remote_irq_input, remote_lock_flag,
      downstream_plug_flag, receiver_found_flag, key_list_ready,
      receiver_key_ready, s_q.auth_done_flag};

   always_comb begin
      events = '0;
      events[IRQ_INDIRECT] = indirect_done_pulse;
      events[IRQ_FOUND] = found_rise;
      events[IRQ_REMOTE] = remote_rise;
      events[IRQ_LIST] = key_list_loaded;
      events[IRQ_KEY] = receiver_key_loaded;
      events[IRQ_FAIL] = auth_fail_pulse;
      events[IRQ_PASS] = auth_pass_pulse;
   end

   always_comb begin
      s_d = s_q;
      s_d.restart = 1'b0;
      // Latched events; a new event beats the read that clears
      for (int i = IRQ_PASS; i <= IRQ_INDIRECT; i++) begin
         if (events[i]) begin
            s_d.irq_st[i] = 1'b1;
         end else if (rd_irq) begin
            s_d.irq_st[i] = 1'b0;
         end
      end
      s_d.irq_st[IRQ_GLOBAL] = any_enabled(s_d.irq_st, s_d.irq_en);
      if (hit(wr, addr, REG_IRQ_EN)) begin
         s_d.irq_en = wdata;
         s_d.irq_st[IRQ_GLOBAL] = any_enabled(s_d.irq_st, wdata);
      end
      if (hit(wr, addr, REG_CFG)) begin
         s_d.needs_lock = wdata[CFG_NEEDS_LOCK];
         s_d.repeater = wdata[CFG_REPEATER];
      end
      if (wr_ctl && wdata[CTL_ENABLE]) begin
         s_d.restart = s_q.enabled;
         s_d.enabled = 1'b1;
      end
      if (auth_pass_pulse) begin
         s_d.auth_done_flag = 1'b1;
      end else if (auth_fail_pulse || s_d.restart) begin
         s_d.auth_done_flag = 1'b0;
      end
      case (s_q.auth)
         PLS_AUTH_IDLE: begin
            if (s_d.enabled) begin
               s_d.auth = PLS_AUTH_RUN;
            end
         end
         PLS_AUTH_RUN: begin
            if ((key_list_loaded) || (receiver_key_loaded && !s_q.repeater)) begin
               s_d.auth = PLS_AUTH_WAIT;
            end
         end
         PLS_AUTH_WAIT: begin
            if (list_approved || key_approved || auth_fail_pulse) begin
               s_d.auth = PLS_AUTH_RUN;
            end
         end
         default: s_d.auth = PLS_AUTH_IDLE;
      endcase
      if (s_d.restart) begin
         s_d.auth = PLS_AUTH_RUN;
      end
      s_d.rdata = '0;
      if (rd) begin
         case (addr)
            REG_STATUS: s_d.rdata = status_byte;
            REG_IRQ_EN: s_d.rdata = s_q.irq_en;
            REG_IRQ_ST: s_d.rdata = s_q.irq_st;
            REG_CFG: s_d.rdata = {5'h00, s_q.repeater, s_q.needs_lock, 1'b0};
            REG_CTRL: s_d.rdata = {7'h00, s_q.enabled};
            default: s_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign irq_out = s_q.irq_st[IRQ_GLOBAL] & s_q.irq_en[IRQ_GLOBAL];
   assign auth_stall = (s_q.auth == PLS_AUTH_WAIT);
   assign auth_enabled = s_q.enabled;
   assign auth_restart = s_q.restart;

   property p_err_set;
      @(posedge clk) disable iff (!rst_b) link_error_pulse |=> link_error_flag;
   endproperty
   a_err_set: assert property (p_err_set) else $error("error flag not set");

   property p_err_clr;
      @(posedge clk) disable iff (!rst_b)
         rd_status && !link_error_pulse |=> !link_error_flag;
   endproperty
   a_err_clr: assert property (p_err_clr) else $error("error flag not cleared");

   property p_mirror;
      @(posedge clk) disable iff (!rst_b)
         rd_status |=> rdata[ST_REMOTE_IRQ] == $past(remote_irq_input)
            && rdata[ST_LOCK] == $past(remote_lock_flag)
            && rdata[ST_FOUND] == $past(receiver_found_flag);
   endproperty
   a_mirror: assert property (p_mirror) else $error("status mirror wrong");

   property p_plug;
      @(posedge clk) disable iff (!rst_b) downstream_plug_pulse |=> downstream_plug_flag;
   endproperty
   a_plug: assert property (p_plug) else $error("plug flag not set");

   property p_list;
      @(posedge clk) disable iff (!rst_b)
         key_list_loaded && s_q.auth == PLS_AUTH_RUN |=> key_list_ready && auth_stall;
   endproperty
   a_list: assert property (p_list) else $error("list stall missing");

   property p_key_clr;
      @(posedge clk) disable iff (!rst_b)
         (key_approved || auth_fail_pulse) && !receiver_key_loaded |=> !receiver_key_ready;
   endproperty
   a_key_clr: assert property (p_key_clr) else $error("key flag not cleared");

   property p_pass;
      @(posedge clk) disable iff (!rst_b)
         auth_pass_pulse |=> s_q.auth_done_flag && s_q.irq_st[IRQ_PASS];
   endproperty
   a_pass: assert property (p_pass) else $error("pass not recorded");

   property p_fail;
      @(posedge clk) disable iff (!rst_b)
         auth_fail_pulse |=> !s_q.auth_done_flag && s_q.irq_st[IRQ_FAIL];
   endproperty
   a_fail: assert property (p_fail) else $error("fail not recorded");

   property p_gate;
      @(posedge clk) disable iff (!rst_b) !s_q.irq_en[IRQ_GLOBAL] |-> !irq_out;
   endproperty
   a_gate: assert property (p_gate) else $error("irq without global enable");

   property p_lock_gate;
      @(posedge clk) disable iff (!rst_b)
         s_q.needs_lock && !remote_lock_flag && !rd_irq ##1 !events[IRQ_FOUND]
            |-> s_q.irq_st[IRQ_FOUND] == $past(s_q.irq_st[IRQ_FOUND]) || rd_irq;
   endproperty
   a_lock_gate: assert property (p_lock_gate) else $error("detect fired without lock");

   property p_any;
      @(posedge clk) disable iff (!rst_b)
         s_q.irq_st[IRQ_GLOBAL] == |(s_q.irq_st[7:1] & s_q.irq_en[7:1]);
   endproperty
   a_any: assert property (p_any) else $error("summary bit wrong");

   property p_restart;
      @(posedge clk) disable iff (!rst_b)
         wr_ctl && wdata[CTL_ENABLE] && s_q.enabled && !auth_pass_pulse
            |=> auth_restart && !s_q.auth_done_flag;
   endproperty
   a_restart: assert property (p_restart) else $error("restart missing");

   property p_irq_clr;
      @(posedge clk) disable iff (!rst_b)
         rd_irq && events == 8'h00 |=> s_q.irq_st[7:1] == 7'h00;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("status not cleared");

   property p_plug_clr;
      @(posedge clk) disable iff (!rst_b)
         rd_status && !downstream_plug_pulse |=> !downstream_plug_flag;
   endproperty
   a_plug_clr: assert property (p_plug_clr) else $error("plug flag not cleared");

   property p_list_clr;
      @(posedge clk) disable iff (!rst_b)
         list_approved && !key_list_loaded |=> !key_list_ready;
   endproperty
   a_list_clr: assert property (p_list_clr) else $error("list flag not cleared");

   property p_key_stall;
      @(posedge clk) disable iff (!rst_b)
         receiver_key_loaded && !s_q.repeater && s_q.auth == PLS_AUTH_RUN && !wr_ctl
            |=> auth_stall && receiver_key_ready;
   endproperty
   a_key_stall: assert property (p_key_stall) else $error("key stall missing");

   property p_fail_go;
      @(posedge clk) disable iff (!rst_b)
         auth_fail_pulse && auth_stall |=> !auth_stall;
   endproperty
   a_fail_go: assert property (p_fail_go) else $error("stall held after failure");

   property p_en_wr;
      @(posedge clk) disable iff (!rst_b)
         wr && addr == REG_IRQ_EN |=> s_q.irq_en == $past(wdata);
   endproperty
   a_en_wr: assert property (p_en_wr) else $error("enable write lost");

   property p_remote;
      @(posedge clk) disable iff (!rst_b)
         $fell(remote_irq_input) |=> s_q.irq_st[IRQ_REMOTE];
   endproperty
   a_remote: assert property (p_remote) else $error("remote request not latched");

   property p_found_irq;
      @(posedge clk) disable iff (!rst_b)
         !s_q.needs_lock && $rose(receiver_found_flag) |=> s_q.irq_st[IRQ_FOUND];
   endproperty
   a_found_irq: assert property (p_found_irq) else $error("detect not latched");
endmodule : pls_top

/* bench/pls_far_model.sv */
/*
 Far-side stand-in for the authentication engine and the remote receiver.
 Assumes one bench process calls its tasks; all changes follow a rising clk.
*/
module pls_far_model (
   // Clock
   clk,
   // Event lines
   link_error_pulse,
   remote_irq_input,
   remote_lock_flag,
   downstream_plug_pulse,
   receiver_found_flag,
   key_list_loaded,
   receiver_key_loaded,
   auth_pass_pulse,
   auth_fail_pulse,
   indirect_done_pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   input wire logic clk;
   output logic link_error_pulse;
   output logic remote_irq_input;
   output logic remote_lock_flag;
   output logic downstream_plug_pulse;
   output logic receiver_found_flag;
   output logic key_list_loaded;
   output logic receiver_key_loaded;
   output logic auth_pass_pulse;
   output logic auth_fail_pulse;
   output logic indirect_done_pulse;

   // Idle levels until the first event; remote interrupt is active low, so idle is high
   initial begin
      link_error_pulse <= 1'b0;
      remote_irq_input <= 1'b1;
      remote_lock_flag <= 1'b0;
      downstream_plug_pulse <= 1'b0;
      receiver_found_flag <= 1'b0;
      key_list_loaded <= 1'b0;
      receiver_key_loaded <= 1'b0;
      auth_pass_pulse <= 1'b0;
      auth_fail_pulse <= 1'b0;
      indirect_done_pulse <= 1'b0;
   end

   // One-cycle event: 0 err, 1 plug, 2 list, 3 key, 4 pass, 5 fail, 6 indirect
   task automatic pulse(input int k);
      @(posedge clk);
      case (k)
         0: link_error_pulse <= 1'b1;
         1: downstream_plug_pulse <= 1'b1;
         2: key_list_loaded <= 1'b1;
         3: receiver_key_loaded <= 1'b1;
         4: auth_pass_pulse <= 1'b1;
         5: auth_fail_pulse <= 1'b1;
         default: indirect_done_pulse <= 1'b1;
      endcase
      @(posedge clk);
      link_error_pulse <= 1'b0;
      downstream_plug_pulse <= 1'b0;
      key_list_loaded <= 1'b0;
      receiver_key_loaded <= 1'b0;
      auth_pass_pulse <= 1'b0;
      auth_fail_pulse <= 1'b0;
      indirect_done_pulse <= 1'b0;
   endtask : pulse

   // Level change: 0 remote interrupt, 1 lock, 2 receiver found
   task automatic level(input int k, input logic v);
      @(posedge clk);
      case (k)
         0: remote_irq_input <= v;
         1: remote_lock_flag <= v;
         default: receiver_found_flag <= v;
      endcase
   endtask : level
endmodule : pls_far_model

/* bench/test_pls_top.sv */
/*
 Self-checking bench for the link status and interrupt block.
 Assumes the far-side model drives all events and the bench owns the register port.
*/
module test_pls_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pls_pkg::*;
   logic clk;
   logic rst_b;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic link_error_pulse, remote_irq_input, remote_lock_flag, downstream_plug_pulse;
   logic receiver_found_flag, key_list_loaded, receiver_key_loaded;
   logic auth_pass_pulse, auth_fail_pulse, indirect_done_pulse;
   logic auth_stall, auth_enabled, auth_restart, irq_out;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   pls_far_model u_pls_far_model (.clk(clk), .link_error_pulse(link_error_pulse),
      .remote_irq_input(remote_irq_input), .remote_lock_flag(remote_lock_flag),
      .downstream_plug_pulse(downstream_plug_pulse), .receiver_found_flag(receiver_found_flag),
      .key_list_loaded(key_list_loaded), .receiver_key_loaded(receiver_key_loaded),
      .auth_pass_pulse(auth_pass_pulse), .auth_fail_pulse(auth_fail_pulse),
      .indirect_done_pulse(indirect_done_pulse));

   pls_top u_pls_top (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .link_error_pulse(link_error_pulse),
      .remote_irq_input(remote_irq_input), .remote_lock_flag(remote_lock_flag),
      .downstream_plug_pulse(downstream_plug_pulse), .receiver_found_flag(receiver_found_flag),
      .key_list_loaded(key_list_loaded), .receiver_key_loaded(receiver_key_loaded),
      .auth_pass_pulse(auth_pass_pulse), .auth_fail_pulse(auth_fail_pulse),
      .indirect_done_pulse(indirect_done_pulse), .auth_stall(auth_stall),
      .auth_enabled(auth_enabled), .auth_restart(auth_restart), .irq_out(irq_out));

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic check_flag(input logic got, input logic exp);
      check({7'h00, got}, {7'h00, exp});
   endtask : check_flag

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : reg_wr

   // Read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask : reg_rd

   // Raise the event behind interrupt status bit i
   task automatic trig(input int i);
      case (i)
         7: u_pls_far_model.pulse(6);
         6: u_pls_far_model.level(2, 1'b1);
         5: u_pls_far_model.level(0, 1'b0);
         4: u_pls_far_model.pulse(2);
         3: u_pls_far_model.pulse(3);
         2: u_pls_far_model.pulse(5);
         default: u_pls_far_model.pulse(4);
      endcase
   endtask : trig

   // Long enough for the whole sequence with a wide margin
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end

   initial begin
      rst_b <= 1'b0;
      addr <= 8'h00;
      wdata <= 8'h00;
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      reg_rd(REG_STATUS, 8'h40);
      reg_rd(REG_IRQ_EN, 8'h00);
      reg_rd(REG_IRQ_ST, 8'h00);
      reg_wr(REG_IRQ_ST, 8'hff);
      reg_rd(REG_IRQ_ST, 8'h00);
      reg_rd(8'h10, 8'h00);
      reg_wr(REG_IRQ_EN, 8'hff);
      reg_rd(REG_IRQ_EN, 8'hff);
      reg_wr(8'hc8, 8'h01);
      check_flag(auth_enabled, 1'b1);
      check_flag(auth_restart, 1'b0);
      u_pls_far_model.pulse(0);
      u_pls_far_model.pulse(1);
      reg_rd(REG_STATUS, 8'hd0);
      reg_rd(REG_STATUS, 8'h40);
      u_pls_far_model.level(1, 1'b1);
      u_pls_far_model.level(2, 1'b1);
      tick(2);
      reg_rd(REG_STATUS, 8'h68);
      u_pls_far_model.level(2, 1'b0);
      u_pls_far_model.level(1, 1'b0);
      u_pls_far_model.pulse(2);
      tick(2);
      check_flag(auth_stall, 1'b1);
      reg_rd(REG_STATUS, 8'h44);
      reg_wr(8'hc8, 8'h20);
      tick(1);
      check_flag(auth_stall, 1'b0);
      reg_rd(REG_STATUS, 8'h40);
      u_pls_far_model.pulse(3);
      tick(2);
      check_flag(auth_stall, 1'b1);
      reg_rd(REG_STATUS, 8'h42);
      u_pls_far_model.pulse(5);
      tick(1);
      check_flag(auth_stall, 1'b0);
      reg_rd(REG_STATUS, 8'h40);
      reg_wr(8'hc8, 8'h01);
      check_flag(auth_restart, 1'b1);
      u_pls_far_model.pulse(4);
      reg_rd(REG_STATUS, 8'h41);
      reg_wr(8'hc8, 8'h01);
      tick(1);
      reg_rd(REG_STATUS, 8'h40);
      reg_rd(REG_IRQ_ST, 8'h5f);
      for (int i = 7; i >= 1; i--) begin
         trig(i);
         tick(3);
         check_flag(irq_out, 1'b1);
         reg_rd(REG_IRQ_ST, 8'h01 | (8'h01 << i));
         reg_rd(REG_IRQ_ST, 8'h00);
         check_flag(irq_out, 1'b0);
      end
      reg_wr(REG_IRQ_EN, 8'hfe);
      u_pls_far_model.pulse(6);
      tick(3);
      check_flag(irq_out, 1'b0);
      reg_rd(REG_IRQ_ST, 8'h81);
      reg_wr(8'hc9, 8'h02);
      u_pls_far_model.level(2, 1'b0);
      u_pls_far_model.level(2, 1'b1);
      tick(3);
      reg_rd(REG_IRQ_ST, 8'h00);
      u_pls_far_model.level(1, 1'b1);
      tick(3);
      reg_rd(REG_IRQ_ST, 8'h41);
      // A repeater does not wait for key approval
      reg_wr(REG_CFG, 8'h04);
      u_pls_far_model.pulse(3);
      tick(2);
      check_flag(auth_stall, 1'b0);
      reg_rd(REG_STATUS, 8'h2f);
      test_done();
   end
endmodule : test_pls_top
